// >>> verification/core_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "prefetch_core_map.vh"
module core_chk #(
    parameter MIN_CLKS = 4
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [2:0] op_i,
    input wire logic op_valid_i,
    input wire logic [31:0] operand_i,
    input wire logic cond_true_i,
    input wire logic [15:0] imm_i,
    input wire logic op_ready_o,
    input wire logic [23:0] bus_addr_o,
    input wire logic bus_req_o,
    input wire logic bus_write_o,
    input wire logic program_ref_o,
    input wire logic [31:0] result_o,
    input wire logic [15:0] status_word_o,
    input wire logic halted_o,
    input wire logic [15:0] periods_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire tk = op_valid_i && op_ready_o;
    reg [15:0] len_q;
    reg [31:0] opd_q;
    reg [15:0] imm_q;
    reg cnd_q;
    // Latch inputs at the take edge, checked one edge later
    always @(posedge core_clk_i)
    begin
        len_q <= (rst_i || !bus_req_o) ? 16'h0000 : len_q + 16'h0001;
        opd_q <= operand_i;
        imm_q <= imm_i;
        cnd_q <= cond_true_i;
    end
    no_write_a: assert property (!bus_write_o)
        else $error("bus write seen");
    fetch_even_a: assert property (bus_req_o |->
        !bus_addr_o[0] && program_ref_o) else $error("bad fetch");
    addr_hold_a: assert property (bus_req_o && $past(bus_req_o)
        |-> $stable(bus_addr_o)) else $error("address moved");
    cycle_len_a: assert property (
        $fell(bus_req_o) && !$past(rst_i) |-> len_q >= MIN_CLKS)
        else $error("bus cycle short");
    periods_up_a: assert property (!$past(rst_i)
        |-> periods_o >= $past(periods_o)) else $error("periods fell");
    refill_a: assert property (tk && op_i != `OP_NONE
        && op_i != `OP_STOP && op_i != `OP_BRANCH
        && op_i != `OP_RET_RESTORE |=> bus_req_o && !op_ready_o)
        else $error("no refill");
    branch_refetch_a: assert property (tk && (op_i == `OP_BRANCH
        || op_i == `OP_RET_RESTORE) |-> ##2 bus_req_o && !op_ready_o)
        else $error("no refetch after branch");
    swap_a: assert property (tk && op_i == `OP_HALF_SWAP |=>
        result_o == {opd_q[15:0], opd_q[31:16]}) else $error("swap");
    tas_a: assert property (tk && op_i == `OP_TEST_SET |=>
        result_o[7:0] == (opd_q[7:0] | 8'h80)) else $error("tas");
    scc_a: assert property (tk && op_i == `OP_COND_SET |=>
        result_o[7:0] == (cnd_q ? `SET_BYTE : `CLR_BYTE)) else $error("scc");
    stop_a: assert property (tk && op_i == `OP_STOP |=>
        halted_o && status_word_o == imm_q) else $error("stop");
endmodule // core_chk
`default_nettype wire

// >>> verification/mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module mem_model (
    input wire logic core_clk_i,
    input wire logic bus_req_i,
    input wire logic [23:0] bus_addr_i,
    input wire logic slow_i,
    output logic [15:0] rd_data_o,
    output logic wait_o
);
    logic [3:0] n_q = 4'h0;
    initial rd_data_o = 16'h0000;
    initial wait_o = 1'b0;
    always @(negedge core_clk_i)
    begin
        n_q <= bus_req_i ? n_q + 4'h1 : 4'h0;
        // Held past the minimum so the cycle really stretches
        wait_o <= slow_i && bus_req_i && n_q < 4'h5;
        // Idle bus shows junk so a stale word cannot pass
        rd_data_o <= bus_req_i ? bus_addr_i[15:0] ^ 16'h5a5a : ~rd_data_o;
    end
endmodule // mem_model
`default_nettype wire

// >>> verification/prefetch_and_execute_core_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "prefetch_core_map.vh"
module prefetch_and_execute_core_test;
    logic core_clk_i = 1'b0, rst_i = 1'b1, op_valid_i = 1'b0;
    logic cond_true_i = 1'b0, exception_i = 1'b0, ea_active_i = 1'b0;
    logic slow = 1'b0;
    logic [2:0] op_i = 3'h0;
    logic [31:0] operand_i = 32'h0;
    logic [15:0] imm_i = 16'h0000, p0;
    logic [23:0] branch_target_i = 24'h000000, t;
    wire [15:0] rd_data_i, decoder_word_o, queued_word_o;
    wire [15:0] status_word_o, periods_o;
    wire wait_i, op_ready_o, bus_req_o, bus_write_o, program_ref_o;
    wire result_valid_o, halted_o;
    wire [23:0] pc_o, bus_addr_o;
    wire [31:0] result_o;
    int miscompares = 0, cmp_count = 0;
    always #10 core_clk_i = ~core_clk_i;
    prefetch_execute_core #(.MIN_CLKS(4)) i_dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .op_i(op_i),
        .op_valid_i(op_valid_i), .operand_i(operand_i),
        .cond_true_i(cond_true_i), .imm_i(imm_i), .exception_i(exception_i),
        .branch_target_i(branch_target_i), .rd_data_i(rd_data_i),
        .wait_i(wait_i), .ea_active_i(ea_active_i),
        .op_ready_o(op_ready_o), .decoder_word_o(decoder_word_o),
        .queued_word_o(queued_word_o), .pc_o(pc_o), .bus_addr_o(bus_addr_o),
        .bus_req_o(bus_req_o), .bus_write_o(bus_write_o),
        .program_ref_o(program_ref_o), .result_o(result_o),
        .result_valid_o(result_valid_o), .status_word_o(status_word_o),
        .halted_o(halted_o), .periods_o(periods_o));
    mem_model i_mem (.core_clk_i(core_clk_i), .bus_req_i(bus_req_o),
        .bus_addr_i(bus_addr_o), .slow_i(slow), .rd_data_o(rd_data_i),
        .wait_o(wait_i));
    function automatic logic [15:0] word_at(input logic [23:0] a);
        return a[15:0] ^ 16'h5a5a;
    endfunction
    task automatic chk(input string s, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        while (op_ready_o !== 1'b1 && n < 300)
        begin
            @(negedge core_clk_i);
            n++;
        end
        chk("op_ready_o", 1, op_ready_o);
    endtask
    task automatic issue(input logic [2:0] op);
        wait_ready;
        op_i = op;
        op_valid_i = 1'b1;
        @(negedge core_clk_i);
        op_valid_i = 1'b0;
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        void'($urandom(32'h272fbd43));
        repeat (8) @(negedge core_clk_i);
        chk("status reset", `RESET_STATUS, status_word_o);
        rst_i = 1'b0;
        wait_ready;
        chk("decoder_word_o", word_at(24'h0), decoder_word_o);
        chk("queued_word_o", word_at(24'h2), queued_word_o);
        chk("pc_o", 24'h2, pc_o);
        for (int k = 0; k < 12; k++)
        begin
            // First pass forces a zero byte for the zero flag
            operand_i = (k < 3) ? 32'h0 : $urandom;
            cond_true_i = 1'($urandom_range(0, 1));
            issue(3'(1 + k % 3));
            chk("result_valid_o", 1, result_valid_o);
            if (op_i == `OP_HALF_SWAP)
                chk("swap", {operand_i[15:0], operand_i[31:16]},
                    result_o);
            if (op_i == `OP_HALF_SWAP)
                chk("swap nz", {operand_i[15],
                    operand_i == 0, 2'b00}, status_word_o[3:0]);
            if (op_i == `OP_TEST_SET)
                chk("tas", {1'b1, operand_i[7],
                    operand_i[7:0] == 0, 2'b00},
                    {result_o[7], status_word_o[3:0]});
            if (op_i == `OP_COND_SET)
                chk("scc", cond_true_i ? 8'hff : 8'h00,
                    result_o[7:0]);
        end
        for (int k = 0; k < 2; k++)
        begin
            slow = k[0];
            wait_ready;
            p0 = periods_o;
            t = pc_o;
            issue(`OP_EXT_USE);
            wait_ready;
            chk("ext pc", t + 24'h2, pc_o);
            chk("ext shift", word_at(t), decoder_word_o);
            chk("ext word", word_at(t + 24'h2), queued_word_o);
            if (k == 0)
                chk("periods", p0 + 16'h4, periods_o);
            else
                chk("stretched", 1, periods_o > p0 + 16'h4);
        end
        slow = 1'b0;
        for (int k = 5; k < 7; k++)
        begin
            t = 24'($urandom) & 24'hfffffe;
            branch_target_i = t;
            operand_i = $urandom;
            issue(k[2:0]);
            if (k == 5)
                chk("restored flags", operand_i[7:0],
                    status_word_o[7:0]);
            wait_ready;
            chk("target word", word_at(t), decoder_word_o);
            chk("target pc", t + 24'h2, pc_o);
        end
        imm_i = 16'($urandom);
        issue(`OP_STOP);
        chk("stop status", imm_i, status_word_o);
        repeat (20) @(negedge core_clk_i);
        chk("halted ready", 0, op_ready_o);
        chk("halted", 1, halted_o);
        t = pc_o;
        exception_i = 1'b1;
        @(negedge core_clk_i);
        exception_i = 1'b0;
        wait_ready;
        chk("halted_o", 0, halted_o);
        chk("refill pc", t + 24'h2, pc_o);
        tally_and_finish;
    end
    initial
    begin
        #400000;
        miscompares++;
        tally_and_finish;
    end
endmodule // prefetch_and_execute_core_test
bind prefetch_execute_core core_chk #(.MIN_CLKS(MIN_CLKS)) u_chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .op_i(op_i),
    .op_valid_i(op_valid_i), .operand_i(operand_i),
    .cond_true_i(cond_true_i), .imm_i(imm_i), .op_ready_o(op_ready_o),
    .bus_addr_o(bus_addr_o), .bus_req_o(bus_req_o),
    .bus_write_o(bus_write_o), .program_ref_o(program_ref_o),
    .result_o(result_o), .status_word_o(status_word_o),
    .halted_o(halted_o), .periods_o(periods_o));
`default_nettype wire

// >>> verilog/bus_cycle_timer.v
`timescale 1ns/1ns
`default_nettype none
module bus_cycle_timer #(
    parameter MIN_CLKS = 4
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire start_i,
    input wire wait_i,
    output reg done_o,
    output reg busy_o,
    output reg [15:0] periods_o
);
    reg [3:0] cnt_q;
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            cnt_q <= 4'h0;
            done_o <= 1'b0;
            busy_o <= 1'b0;
            periods_o <= 16'h0000;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i && !busy_o)
            begin
                busy_o <= 1'b1;
                cnt_q <= 4'h1;
                periods_o <= periods_o + 16'h0001;
            end
            else if (busy_o)
            begin
                periods_o <= periods_o + 16'h0001;
                // Wait states stretch the cycle past the minimum
                if (cnt_q >= MIN_CLKS[3:0] - 4'h1 && !wait_i)
                begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                else if (cnt_q < MIN_CLKS[3:0])
                begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule // bus_cycle_timer
`default_nettype wire

// >>> verilog/prefetch_core_map.vh
`ifndef PREFETCH_CORE_MAP_VH
`define PREFETCH_CORE_MAP_VH
`define PQ_DEPTH 2
`define BUS_MIN_CLKS 4
`define OP_NONE 3'h0
`define OP_HALF_SWAP 3'h1
`define OP_TEST_SET 3'h2
`define OP_COND_SET 3'h3
`define OP_STOP 3'h4
`define OP_RET_RESTORE 3'h5
`define OP_BRANCH 3'h6
`define OP_EXT_USE 3'h7
`define FLAG_C 0
`define FLAG_V 1
`define FLAG_Z 2
`define FLAG_N 3
`define TS_BIT 7
`define SET_BYTE 8'hff
`define CLR_BYTE 8'h00
`define RESET_PC 24'h000000
`define RESET_STATUS 16'h2700
`endif

// >>> verilog/prefetch_execute_core.v
`timescale 1ns/1ns
`default_nettype none
`include "prefetch_core_map.vh"
// Functional notes
// - Two-word prefetch queue overlaps fetch with execution
// - Opword decoded and next word prefetched
// - Each consumed extension word triggers refill fetch
// - Last fetch issued when next decode starts
// - Branch discards prefetched word, fetch still happened
// - Exceptions discard both queued words
// - PC holds last fetched word address
// - Bus cycle is four clocks, no waits
// - Wait states add clocks to cycle
// - Period count includes fetch cycles and their wait states
// - Half swap exchanges halves, sets N Z
// - Test-set flags byte then sets bit 7
// - Conditional set writes ones or zeros
// - Stop loads status word then halts
// - Return pops flags and program counter at the same edge
// - Address evaluation never writes the bus
module prefetch_execute_core #(
    parameter MIN_CLKS = `BUS_MIN_CLKS
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire [2:0] op_i,
    input wire op_valid_i,
    input wire [31:0] operand_i,
    input wire cond_true_i,
    input wire [15:0] imm_i,
    input wire exception_i,
    input wire [23:0] branch_target_i,
    input wire [15:0] rd_data_i,
    input wire wait_i,
    input wire ea_active_i,
    output reg op_ready_o,
    output reg [15:0] decoder_word_o,
    output reg [15:0] queued_word_o,
    output reg [23:0] pc_o,
    output reg [23:0] bus_addr_o,
    output reg bus_req_o,
    output reg bus_write_o,
    output reg program_ref_o,
    output reg [31:0] result_o,
    output reg result_valid_o,
    output reg [15:0] status_word_o,
    output reg halted_o,
    output reg [15:0] periods_o
);
    localparam ST_FILL = 2'h0;
    localparam ST_READY = 2'h1;
    localparam ST_FETCH = 2'h2;
    localparam ST_HALT = 2'h3;
    reg [1:0] state_q;
    reg [15:0] pq_q [0:`PQ_DEPTH-1];
    reg [1:0] count_q;
    reg start_q;
    wire done;
    wire busy;
    wire [15:0] periods;
    wire [7:0] byte_v = operand_i[7:0];
    wire [31:0] swapped = {operand_i[15:0], operand_i[31:16]};
    bus_cycle_timer #(.MIN_CLKS(MIN_CLKS)) timer_u (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .start_i(start_q),
        .wait_i(wait_i),
        .done_o(done),
        .busy_o(busy),
        .periods_o(periods)
    );
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            state_q <= ST_FILL;
            pq_q[0] <= 16'h0000;
            pq_q[1] <= 16'h0000;
            count_q <= 2'h0;
            start_q <= 1'b0;
            op_ready_o <= 1'b0;
            decoder_word_o <= 16'h0000;
            queued_word_o <= 16'h0000;
            pc_o <= `RESET_PC;
            bus_addr_o <= `RESET_PC;
            bus_req_o <= 1'b0;
            bus_write_o <= 1'b0;
            program_ref_o <= 1'b0;
            result_o <= 32'h00000000;
            result_valid_o <= 1'b0;
            status_word_o <= `RESET_STATUS;
            halted_o <= 1'b0;
            periods_o <= 16'h0000;
        end
        else
        begin
            start_q <= 1'b0;
            result_valid_o <= 1'b0;
            periods_o <= periods;
            bus_write_o <= 1'b0;
            decoder_word_o <= pq_q[0];
            queued_word_o <= pq_q[1];
            if (done)
            begin
                bus_req_o <= 1'b0;
                program_ref_o <= 1'b0;
                pq_q[count_q[0]] <= rd_data_i;
                count_q <= count_q + 2'h1;
                pc_o <= bus_addr_o;
            end
            if (exception_i)
            begin
                // Queue contents are dropped, refill restarts at pc_o
                count_q <= 2'h0;
                halted_o <= 1'b0;
                op_ready_o <= 1'b0;
                state_q <= ST_FILL;
            end
            else
            begin
                case (state_q)
                ST_FILL:
                begin
                    op_ready_o <= 1'b0;
                    if (count_q == `PQ_DEPTH && !busy)
                    begin
                        op_ready_o <= 1'b1;
                        state_q <= ST_READY;
                    end
                    else if (!busy && !start_q && !done && !bus_req_o)
                    begin
                        // Empty queue restarts the stream at pc_o itself
                        if (count_q == 2'h0)
                        begin
                            bus_addr_o <= {pc_o[23:1], 1'b0};
                        end
                        else
                        begin
                            bus_addr_o <= {pc_o[23:1] + 23'h1, 1'b0};
                        end
                        bus_req_o <= 1'b1;
                        program_ref_o <= 1'b1;
                        start_q <= 1'b1;
                    end
                end
                ST_READY:
                begin
                    if (op_valid_i)
                    begin
                        op_ready_o <= 1'b0;
                        result_valid_o <= 1'b1;
                        result_o <= operand_i;
                        case (op_i)
                        `OP_HALF_SWAP:
                        begin
                            result_o <= swapped;
                            status_word_o[`FLAG_N] <= swapped[31];
                            status_word_o[`FLAG_Z] <= swapped == 32'h0;
                            status_word_o[`FLAG_V] <= 1'b0;
                            status_word_o[`FLAG_C] <= 1'b0;
                        end
                        `OP_TEST_SET:
                        begin
                            status_word_o[`FLAG_N] <= byte_v[7];
                            status_word_o[`FLAG_Z] <= byte_v == 8'h00;
                            status_word_o[`FLAG_V] <= 1'b0;
                            status_word_o[`FLAG_C] <= 1'b0;
                            result_o <= {operand_i[31:8],
                                byte_v | 8'h80};
                        end
                        `OP_COND_SET:
                            result_o <= {operand_i[31:8], cond_true_i ?
                                `SET_BYTE : `CLR_BYTE};
                        `OP_STOP:
                        begin
                            status_word_o <= imm_i;
                            halted_o <= 1'b1;
                        end
                        `OP_RET_RESTORE:
                        begin
                            // Popped flag byte and target are both taken at the same edge
                            status_word_o[7:0] <= operand_i[7:0];
                            pc_o <= {branch_target_i[23:1], 1'b0};
                        end
                        `OP_BRANCH:
                            pc_o <= {branch_target_i[23:1], 1'b0};
                        default:
                            result_valid_o <= 1'b0;
                        endcase
                        if (op_i == `OP_STOP)
                        begin
                            state_q <= ST_HALT;
                        end
                        else if (op_i == `OP_BRANCH ||
                            op_i == `OP_RET_RESTORE)
                        begin
                            // Prefetched word was already paid for
                            count_q <= 2'h0;
                            state_q <= ST_FILL;
                        end
                        else
                        begin
                            // Extension use or opword drop: shift, refill
                            pq_q[0] <= pq_q[1];
                            count_q <= count_q - 2'h1;
                            bus_addr_o <= {pc_o[23:1] + 23'h1, 1'b0};
                            bus_req_o <= 1'b1;
                            program_ref_o <= 1'b1;
                            start_q <= 1'b1;
                            state_q <= ST_FETCH;
                        end
                    end
                end
                ST_FETCH:
                begin
                    // One edge later so queued_word_o shows the new word
                    if (count_q == `PQ_DEPTH && !busy)
                    begin
                        op_ready_o <= 1'b1;
                        state_q <= ST_READY;
                    end
                end
                ST_HALT:
                    halted_o <= 1'b1;
                default:
                    state_q <= ST_FILL;
                endcase
            end
        end
    end
endmodule // prefetch_execute_core
`default_nettype wire
